// >>> dac_pkg.sv
`default_nettype none

package dac_pkg;

  // Widths of the programming word and its fields
  localparam int DAC_WORD_BITS  = 16;
  localparam int DAC_DATA_BITS  = 10;
  localparam int DAC_SUB_BITS   = 8;
  localparam int DAC_ADDR_BITS  = 3;
  localparam int DAC_MAX_CHAN   = 8;

  // Serial word field positions
  localparam int SER_SUB_POS    = 15;
  localparam int SER_KIND_HI    = 14;
  localparam int SER_KIND_LO    = 13;
  localparam int SER_ADDR_HI    = 12;
  localparam int SER_ADDR_LO    = 10;

  // Serial word kind codes, taken from bits 14:13
  localparam logic [1:0] SER_KIND_SYS  = 2'h0;
  localparam logic [1:0] SER_KIND_CHAN = 2'h2;
  localparam logic [1:0] SER_KIND_DATA = 2'h1;

  // System control field positions
  localparam int SYS_MUX_LO     = 0;
  localparam int SYS_MUX_HI     = 1;
  localparam int SYS_BYTE_POS   = 4;
  localparam int SYS_NORMAL_POS = 5;
  localparam int SYS_OFFBIN_POS = 6;

  // Channel control field positions
  localparam int CHN_MAIN_POS   = 0;
  localparam int CHN_INTREF_POS = 4;
  localparam int CHN_EXTREF_POS = 9;

  // Values after reset
  localparam logic [9:0] SYS_RESET  = 10'h000;
  localparam logic [9:0] CHN_RESET  = 10'h001;
  localparam logic [9:0] MAIN_RESET = 10'h000;
  localparam logic [7:0] SUB_RESET  = 8'h00;

  // Code conversion masks from twos complement to straight binary
  localparam logic [9:0] MAIN_TWOS_FLIP = 10'h200;
  localparam logic [7:0] SUB_TWOS_FLIP  = 8'h7F;

  // Bit count of a serial frame
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;

  // Destination of one decoded write
  typedef enum logic [2:0] {
    DAC_TGT_NONE,
    DAC_TGT_SYS,
    DAC_TGT_CHAN,
    DAC_TGT_MAIN,
    DAC_TGT_SUB
  } dac_target_type;

  // One decoded write, from either bus
  typedef struct packed {
    dac_target_type     target;
    logic [2:0]         chan;
    logic [9:0]         data;
  } dac_wr_type;

  // Pins after the synchroniser
  typedef struct packed {
    logic               sclk;
    logic               fsync_n;
    logic               sdata;
    logic               wr_n;
    logic               mode;
    logic [2:0]         addr;
    logic [9:0]         data;
    logic               load_n;
  } dac_pins_type;

  // Pin levels the synchroniser shows during and just after reset
  localparam dac_pins_type PINS_IDLE = '{sclk: 1'b0, fsync_n: 1'b1, sdata: 1'b0,
                                         wr_n: 1'b1, mode: 1'b0, addr: 3'h0,
                                         data: 10'h000, load_n: 1'b1};

endpackage

`default_nettype wire

// >>> dac_sync.sv
`default_nettype none

module dac_sync
  import dac_pkg::*;
#(
  parameter int               WIDTH     = 1,    // Number of signals carried
  parameter logic [WIDTH-1:0] RESET_VAL = '0    // Idle levels held during reset
)
(
  input  wire logic             CORE_CLK,   // Core clock
  input  wire logic             SYS_RST,    // Asynchronous reset, active high
  input  wire logic             CLK_EN,     // Freezes state while low
  input  wire logic [WIDTH-1:0] ASYNC_IN,   // Signals from outside the domain
  output logic      [WIDTH-1:0] SYNC_OUT    // Two-stage synchronised copy
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] stage1;

  // Two flip-flops; only the second reads the first. Both start at the idle
  // levels, so edge detectors behind them see no false edge after reset
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      stage1   <= RESET_VAL;
      SYNC_OUT <= RESET_VAL;
    end
    else if (CLK_EN)
    begin
      stage1   <= ASYNC_IN;
      SYNC_OUT <= stage1;
    end
  end

endmodule

`default_nettype wire

// >>> dac_serial_rx.sv
`default_nettype none

module dac_serial_rx
  import dac_pkg::*;
(
  input  wire logic        CORE_CLK,    // Core clock
  input  wire logic        SYS_RST,     // Asynchronous reset, active high
  input  wire logic        CLK_EN,      // Freezes state while low
  input  wire logic        SCLK,        // Synchronised serial clock
  input  wire logic        FSYNC_N,     // Synchronised frame sync, active low
  input  wire logic        SDATA,       // Synchronised serial data
  output logic      [15:0] WORD,        // Last complete word
  output logic             WORD_VALID   // One-cycle pulse per complete word
);

  logic        sclk_prev;
  logic [15:0] shift;
  logic [4:0]  count;
  logic        fall;

  assign fall = sclk_prev & ~SCLK;

  // Remember the clock level to find its falling edge
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sclk_prev <= 1'b0;
    end
    else if (CLK_EN)
    begin
      sclk_prev <= SCLK;
    end
  end

  // Shift in MSB first on each falling edge inside the frame
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      shift      <= 16'h0000;
      count      <= 5'h00;
      WORD       <= 16'h0000;
      WORD_VALID <= 1'b0;
    end
    else if (CLK_EN)
    begin
      WORD_VALID <= 1'b0;
      if (FSYNC_N)
      begin
        count <= 5'h00;
      end
      else if (fall)
      begin
        shift <= {shift[14:0], SDATA};
        if (count == SER_FRAME_BITS - 5'h01)
        begin
          WORD       <= {shift[14:0], SDATA};
          WORD_VALID <= 1'b1;
          count      <= 5'h00;
        end
        else
        begin
          count <= count + 5'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> dac_prog.sv
`default_nettype none

// What this block does
// - Mode low: parallel write hits system control
// - Mode low: no channel control write; serial only
// - Mode high: data goes to addressed channel
// - Value 020 hex: parallel, twos complement, normal
// - Twos main: 200 zero, 1FF full scale
// - Sub DAC selected: data loads Sub DAC
// - Twos sub: 7F zero, 80 full scale
// - Value 011 hex: internal bias, main target
// - Offset binary main: unsigned 0..1023, 512 mid
// - Offset binary sub: unsigned 0..255, 128 mid
// - Reference mux bits route the reference
// - Serial 0060 hex: system write, offset binary
// - Serial 4210 hex: channel A external reference
// - Serial 23FF hex: channel A main full scale
// - Serial A3FF hex: channel A sub full scale
// - Sample on falling clock, frame held low
// - Load held low: update after sixteenth clock
module dac_prog
  import dac_pkg::*;
#(
  parameter int N_CHAN = 8
)
(
  input  wire logic                  CORE_CLK,              // Core clock, 20 MHz
  input  wire logic                  SYS_RST,               // Asynchronous reset, active high
  input  wire logic                  CLK_EN,                // Freezes all state while low
  input  wire logic                  SERIAL_CLOCK_IN,       // Serial clock pin
  input  wire logic                  FRAME_SYNC_N,          // Serial frame, active low
  input  wire logic                  SERIAL_DATA_IN,        // Serial data pin
  input  wire logic                  PAR_WRITE_N,           // Parallel write strobe, active low
  input  wire logic                  PAR_MODE,              // Parallel mode: 0 control, 1 data
  input  wire logic                  CHANNEL_SELECT_BIT2,   // Channel address bit 2
  input  wire logic                  CHANNEL_SELECT_BIT1,   // Channel address bit 1
  input  wire logic                  CHANNEL_SELECT_BIT0,   // Channel address bit 0
  input  wire logic [9:0]            PAR_DATA,              // Parallel data bus
  input  wire logic                  LOAD_STROBE_N,         // Output update, active low
  output logic      [N_CHAN*10-1:0]  MAIN_CODE,             // Main DAC codes, straight binary
  output logic      [N_CHAN*8-1:0]   SUB_CODE,              // Sub DAC codes, straight binary
  output logic      [N_CHAN-1:0]     BIAS_INTERNAL,         // Channel uses half-supply bias
  output logic      [N_CHAN-1:0]     BIAS_EXTERNAL,         // Channel uses external reference
  output logic                       REFERENCE_MUX_BIT1,    // Reference mux select bit 1
  output logic                       REFERENCE_MUX_BIT0,    // Reference mux select bit 0
  output logic                       OFFSET_BINARY,         // 1 offset binary, 0 twos complement
  output logic                       BYTE_LOAD,             // 1 byte loading, 0 10-bit loading
  output logic                       POWER_DOWN             // Device powered down
);

  generate
    if (N_CHAN < 1 || N_CHAN > DAC_MAX_CHAN)
    begin : g_bad_chan
      $error("N_CHAN must lie between 1 and 8");
    end
  endgenerate

  dac_pins_type pins_raw;
  dac_pins_type pins;
  logic [15:0]  ser_word;
  logic         ser_valid;
  logic         wr_n_prev;
  logic         par_take;
  logic         par_to_main;
  dac_wr_type   next_wr;

  logic [9:0]   sys_ctrl;
  logic [9:0]   chan_ctrl [N_CHAN];
  logic [9:0]   main_in   [N_CHAN];
  logic [7:0]   sub_in    [N_CHAN];
  logic [9:0]   main_lat  [N_CHAN];
  logic [7:0]   sub_lat   [N_CHAN];

  // Gather pins for the synchroniser
  assign pins_raw = '{sclk:    SERIAL_CLOCK_IN,
                      fsync_n: FRAME_SYNC_N,
                      sdata:   SERIAL_DATA_IN,
                      wr_n:    PAR_WRITE_N,
                      mode:    PAR_MODE,
                      addr:    {CHANNEL_SELECT_BIT2, CHANNEL_SELECT_BIT1,
                                CHANNEL_SELECT_BIT0},
                      data:    PAR_DATA,
                      load_n:  LOAD_STROBE_N};

  dac_sync #(
    .WIDTH     ($bits(dac_pins_type)),
    .RESET_VAL (PINS_IDLE)
  ) u_sync (
    .CORE_CLK  (CORE_CLK),
    .SYS_RST   (SYS_RST),
    .CLK_EN    (CLK_EN),
    .ASYNC_IN  (pins_raw),
    .SYNC_OUT  (pins)
  );

  dac_serial_rx u_serial (
    .CORE_CLK   (CORE_CLK),
    .SYS_RST    (SYS_RST),
    .CLK_EN     (CLK_EN),
    .SCLK       (pins.sclk),
    .FSYNC_N    (pins.fsync_n),
    .SDATA      (pins.sdata),
    .WORD       (ser_word),
    .WORD_VALID (ser_valid)
  );

  // Parallel write is taken on the rising edge of the write strobe
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_n_prev <= 1'b1;
    end
    else if (CLK_EN)
    begin
      wr_n_prev <= pins.wr_n;
    end
  end

  assign par_take = ~wr_n_prev & pins.wr_n;

  // Data target of the addressed channel; an absent channel reads as main
  // and is never written, so no index ever leaves the array
  always_comb
  begin
    par_to_main = 1'b1;
    for (int i = 0; i < N_CHAN; i++)
    begin
      if (pins.addr == 3'(i))
      begin
        par_to_main = chan_ctrl[i][CHN_MAIN_POS];
      end
    end
  end

  // Decode one write; a parallel write wins when both arrive together
  always_comb
  begin
    next_wr = '{target: DAC_TGT_NONE, chan: 3'h0, data: 10'h000};
    if (par_take)
    begin
      next_wr.data = pins.data;
      next_wr.chan = pins.addr;
      if (!pins.mode)
      begin
        // Control writes: a channel address of zero with bit 9 data clear
        // would be ambiguous, so the channel control is flagged by kind bits 14:13
        // only in serial; in parallel mode low always reaches system control
        next_wr.target = DAC_TGT_SYS;
        next_wr.chan   = 3'h0;
      end
      else if (par_to_main)
      begin
        next_wr.target = DAC_TGT_MAIN;
      end
      else
      begin
        next_wr.target = DAC_TGT_SUB;
      end
    end
    else if (ser_valid)
    begin
      next_wr.data = ser_word[9:0];
      next_wr.chan = ser_word[SER_ADDR_HI:SER_ADDR_LO];
      unique case (ser_word[SER_KIND_HI:SER_KIND_LO])
        SER_KIND_SYS:  next_wr.target = DAC_TGT_SYS;
        SER_KIND_CHAN: next_wr.target = DAC_TGT_CHAN;
        SER_KIND_DATA: next_wr.target = ser_word[SER_SUB_POS] ?
                                        DAC_TGT_SUB : DAC_TGT_MAIN;
        default:       next_wr.target = DAC_TGT_NONE;
      endcase
    end
  end

  // System control register, held until rewritten
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sys_ctrl <= SYS_RESET;
    end
    else if (CLK_EN && next_wr.target == DAC_TGT_SYS)
    begin
      sys_ctrl <= next_wr.data;
    end
  end

  // Per-channel control and input registers
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < N_CHAN; i++)
      begin
        chan_ctrl[i] <= CHN_RESET;
        main_in[i]   <= MAIN_RESET;
        sub_in[i]    <= SUB_RESET;
      end
    end
    else if (CLK_EN && int'(next_wr.chan) < N_CHAN)
    begin
      unique case (next_wr.target)
        DAC_TGT_CHAN: chan_ctrl[next_wr.chan] <= next_wr.data;
        DAC_TGT_MAIN: main_in[next_wr.chan]   <= next_wr.data;
        DAC_TGT_SUB:  sub_in[next_wr.chan]    <= next_wr.data[7:0];
        DAC_TGT_SYS,
        DAC_TGT_NONE: ;
      endcase
    end
  end

  // DAC latches follow the input registers while the load strobe is low
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < N_CHAN; i++)
      begin
        main_lat[i] <= MAIN_RESET;
        sub_lat[i]  <= SUB_RESET;
      end
    end
    else if (CLK_EN && !pins.load_n)
    begin
      for (int i = 0; i < N_CHAN; i++)
      begin
        main_lat[i] <= main_in[i];
        sub_lat[i]  <= sub_in[i];
      end
    end
  end

  // Registered codes in straight binary: 0 is zero scale
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      MAIN_CODE <= '0;
      SUB_CODE  <= '0;
    end
    else if (CLK_EN)
    begin
      for (int i = 0; i < N_CHAN; i++)
      begin
        if (sys_ctrl[SYS_OFFBIN_POS])
        begin
          MAIN_CODE[i*10 +: 10] <= main_lat[i];
          SUB_CODE[i*8 +: 8]    <= sub_lat[i];
        end
        else
        begin
          MAIN_CODE[i*10 +: 10] <= main_lat[i] ^ MAIN_TWOS_FLIP;
          SUB_CODE[i*8 +: 8]    <= sub_lat[i] ^ SUB_TWOS_FLIP;
        end
      end
    end
  end

  // Bias source per channel; the external bit overrides the internal one,
  // so a word that sets both selects the external reference
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      BIAS_INTERNAL <= '0;
      BIAS_EXTERNAL <= '0;
    end
    else if (CLK_EN)
    begin
      for (int i = 0; i < N_CHAN; i++)
      begin
        BIAS_INTERNAL[i] <= chan_ctrl[i][CHN_INTREF_POS] &
                            ~chan_ctrl[i][CHN_EXTREF_POS];
        BIAS_EXTERNAL[i] <= chan_ctrl[i][CHN_EXTREF_POS];
      end
    end
  end

  // System control outputs
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      REFERENCE_MUX_BIT1 <= 1'b0;
      REFERENCE_MUX_BIT0 <= 1'b0;
      OFFSET_BINARY      <= 1'b0;
      BYTE_LOAD          <= 1'b0;
      POWER_DOWN         <= 1'b1;
    end
    else if (CLK_EN)
    begin
      REFERENCE_MUX_BIT1 <= sys_ctrl[SYS_MUX_HI];
      REFERENCE_MUX_BIT0 <= sys_ctrl[SYS_MUX_LO];
      OFFSET_BINARY      <= sys_ctrl[SYS_OFFBIN_POS];
      BYTE_LOAD          <= sys_ctrl[SYS_BYTE_POS];
      POWER_DOWN         <= ~sys_ctrl[SYS_NORMAL_POS];
    end
  end

endmodule

`default_nettype wire

// >>> dac_prog_checker.sv
`default_nettype none

module dac_prog_checker
  import dac_pkg::*;
#(
  parameter int N_CHAN = 8
)
(
  input wire logic                CORE_CLK,            // Core clock
  input wire logic                SYS_RST,             // Reset, active high
  input wire logic                FRAME_SYNC_N,        // Serial frame
  input wire logic                PAR_WRITE_N,         // Parallel strobe
  input wire logic                PAR_MODE,            // Parallel mode
  input wire logic [9:0]          PAR_DATA,            // Parallel data
  input wire logic                LOAD_STROBE_N,       // Output update
  input wire logic [N_CHAN*10-1:0] MAIN_CODE,          // Main codes
  input wire logic [N_CHAN*8-1:0] SUB_CODE,            // Sub codes
  input wire logic [N_CHAN-1:0]   BIAS_INTERNAL,       // Internal bias
  input wire logic [N_CHAN-1:0]   BIAS_EXTERNAL,       // External reference
  input wire logic                REFERENCE_MUX_BIT1,  // Mux bit 1
  input wire logic                REFERENCE_MUX_BIT0,  // Mux bit 0
  input wire logic                OFFSET_BINARY,       // Coding
  input wire logic                BYTE_LOAD,           // Loading width
  input wire logic                POWER_DOWN           // Powered down
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  logic [9:0] sys_wd;

  // Keeps the data of the last parallel control write
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sys_wd <= 10'h000;
    else if ($rose(PAR_WRITE_N) && !PAR_MODE)
      sys_wd <= PAR_DATA;
  end

  // Reset and hold behaviour
  AST_RESET_STATE: assert property (
    disable iff (1'b0) SYS_RST |-> POWER_DOWN && !OFFSET_BINARY && !BYTE_LOAD)
    else $error("reset state wrong");
  AST_TWOS_RESET_MAP: assert property (
    $fell(SYS_RST) |-> ##[0:2] (MAIN_CODE[9:0] == 10'h200 && SUB_CODE[7:0] == 8'h7F))
    else $error("twos mapping of zero latch wrong");
  AST_LOAD_HOLD: assert property (
    (LOAD_STROBE_N && $stable(OFFSET_BINARY))[*8] ##1 $stable(OFFSET_BINARY)
    |-> $stable(MAIN_CODE) && $stable(SUB_CODE))
    else $error("codes moved while load high");
  AST_BIAS_HOLD: assert property (
    (FRAME_SYNC_N && PAR_WRITE_N)[*8] |=> $stable(BIAS_INTERNAL) && $stable(BIAS_EXTERNAL))
    else $error("bias changed without a write");

  // Parallel control writes land in system control
  AST_SYS_MUX: assert property (
    $rose(PAR_WRITE_N) && !PAR_MODE
    |-> ##[2:10] ({REFERENCE_MUX_BIT1, REFERENCE_MUX_BIT0} == sys_wd[1:0]))
    else $error("mux bits not from control write");
  AST_SYS_CODING: assert property (
    $rose(PAR_WRITE_N) && !PAR_MODE |-> ##[2:10] (OFFSET_BINARY == sys_wd[6]))
    else $error("coding not from control write");
  AST_SYS_POWER: assert property (
    $rose(PAR_WRITE_N) && !PAR_MODE |-> ##[2:10] (POWER_DOWN == !sys_wd[5]))
    else $error("power down not from control write");
  AST_SYS_WIDTH: assert property (
    $rose(PAR_WRITE_N) && !PAR_MODE |-> ##[2:10] (BYTE_LOAD == sys_wd[4]))
    else $error("load width not from control write");
endmodule

`default_nettype wire

// >>> dac_host_model.sv
`default_nettype none

module dac_host_model
(
  output logic sclk,     // Serial clock, parked high
  output logic frame_n,  // Frame sync, active low
  output logic sdata     // Serial data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels between frames
  initial
  begin
    sclk = 1'b1;
    frame_n = 1'b1;
    sdata = 1'b0;
  end

  // Shifts one word, data set while clock high, sampled on its fall
  task automatic send(input logic [15:0] w);
    frame_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdata = w[i];
      #200;
      sclk = 1'b0;
      #200;
      sclk = 1'b1;
    end
    #200;
    frame_n = 1'b1;
    sdata = ~sdata;  // Released line shows no stale value
  endtask
endmodule

`default_nettype wire

// >>> tb_dac_prog.sv
`default_nettype none

module tb_dac_prog;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  logic        en = 1'b1;
  logic        wr_n = 1'b1;
  logic        mode = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [9:0]  pdata = 10'h000;
  logic        load_n = 1'b0;
  wire logic   sclk;
  wire logic   fs_n;
  wire logic   sdat;
  wire logic [79:0] main_code;
  wire logic [63:0] sub_code;
  wire logic [7:0]  b_int;
  wire logic [7:0]  b_ext;
  wire logic   mux1;
  wire logic   mux0;
  wire logic   offbin;
  wire logic   byteld;
  wire logic   pdown;
  int          mismatches = 0;
  int          n_tests = 0;

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  dac_prog #(.N_CHAN(8)) u_dac_prog (
    .CORE_CLK(core_clk), .SYS_RST(rst), .CLK_EN(en),
    .SERIAL_CLOCK_IN(sclk), .FRAME_SYNC_N(fs_n), .SERIAL_DATA_IN(sdat),
    .PAR_WRITE_N(wr_n), .PAR_MODE(mode), .CHANNEL_SELECT_BIT2(addr[2]),
    .CHANNEL_SELECT_BIT1(addr[1]), .CHANNEL_SELECT_BIT0(addr[0]),
    .PAR_DATA(pdata), .LOAD_STROBE_N(load_n), .MAIN_CODE(main_code),
    .SUB_CODE(sub_code), .BIAS_INTERNAL(b_int), .BIAS_EXTERNAL(b_ext),
    .REFERENCE_MUX_BIT1(mux1), .REFERENCE_MUX_BIT0(mux0),
    .OFFSET_BINARY(offbin), .BYTE_LOAD(byteld), .POWER_DOWN(pdown));

  dac_host_model u_dac_host_model (.sclk(sclk), .frame_n(fs_n), .sdata(sdat));

  // Compares one code or flag, zero extended to ten bits
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outputs follow a write within a few cycles
  task automatic settle();
    repeat (12) @(negedge core_clk);
  endtask

  // Parallel write, taken when the strobe rises
  task automatic par_wr(input logic m, input logic [2:0] a, input logic [9:0] d);
    @(negedge core_clk);
    mode = m;
    addr = a;
    pdata = d;
    wr_n = 1'b0;
    repeat (4) @(negedge core_clk);
    wr_n = 1'b1;
    settle();
  endtask

  task automatic ser_wr(input logic [15:0] w);
    u_dac_host_model.send(w);
    settle();
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    #500_000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial
  begin
    #1 rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    settle();
    chk("power_down", 10'h001, {9'h0, pdown});
    chk("main0", 10'h200, main_code[9:0]);
    chk("sub0", 10'h07F, {2'h0, sub_code[7:0]});
    par_wr(1'b0, 3'h7, 10'h020);
    chk("power_down", 10'h000, {9'h0, pdown});
    chk("offset_binary", 10'h000, {9'h0, offbin});
    chk("byte_load", 10'h000, {9'h0, byteld});
    par_wr(1'b1, 3'h3, 10'h1FF);
    chk("main3", 10'h3FF, main_code[39:30]);
    chk("main0", 10'h200, main_code[9:0]);
    ser_wr(16'h0060);
    chk("offset_binary", 10'h001, {9'h0, offbin});
    chk("main3", 10'h1FF, main_code[39:30]);
    ser_wr(16'h23FF);
    chk("main0", 10'h3FF, main_code[9:0]);
    ser_wr(16'hA3FF);
    chk("sub0", 10'h0FF, {2'h0, sub_code[7:0]});
    chk("main0", 10'h3FF, main_code[9:0]);
    ser_wr(16'h4210);
    chk("bias_ext", 10'h001, {2'h0, b_ext});
    ser_wr(16'h4411);
    chk("bias_int", 10'h002, {2'h0, b_int});
    chk("bias_ext", 10'h001, {2'h0, b_ext});
    par_wr(1'b1, 3'h0, 10'h080);
    chk("sub0", 10'h080, {2'h0, sub_code[7:0]});
    chk("main0", 10'h3FF, main_code[9:0]);
    par_wr(1'b1, 3'h1, 10'h200);
    chk("main1", 10'h200, main_code[19:10]);
    load_n = 1'b1;
    ser_wr(16'h2C00);
    chk("main3", 10'h1FF, main_code[39:30]);
    load_n = 1'b0;
    settle();
    chk("main3", 10'h000, main_code[39:30]);
    ser_wr(16'h0063);
    chk("mux", 10'h003, {8'h00, mux1, mux0});
    // A write made while the clock enable is low is never seen
    en = 1'b0;
    par_wr(1'b1, 3'h3, 10'h155);
    en = 1'b1;
    settle();
    chk("main3", 10'h000, main_code[39:30]);
    // Reset in mid-run brings every register back to its reset value
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("power_down", 10'h001, {9'h0, pdown});
    rst = 1'b0;
    settle();
    chk("mux", 10'h000, {8'h00, mux1, mux0});
    chk("main3", 10'h200, main_code[39:30]);
    chk("bias_int", 10'h000, {2'h0, b_int});
    test_done();
  end
endmodule

bind dac_prog dac_prog_checker #(.N_CHAN(N_CHAN)) u_dac_prog_checker (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .FRAME_SYNC_N(FRAME_SYNC_N),
  .PAR_WRITE_N(PAR_WRITE_N), .PAR_MODE(PAR_MODE), .PAR_DATA(PAR_DATA),
  .LOAD_STROBE_N(LOAD_STROBE_N), .MAIN_CODE(MAIN_CODE), .SUB_CODE(SUB_CODE),
  .BIAS_INTERNAL(BIAS_INTERNAL), .BIAS_EXTERNAL(BIAS_EXTERNAL),
  .REFERENCE_MUX_BIT1(REFERENCE_MUX_BIT1), .REFERENCE_MUX_BIT0(REFERENCE_MUX_BIT0),
  .OFFSET_BINARY(OFFSET_BINARY), .BYTE_LOAD(BYTE_LOAD), .POWER_DOWN(POWER_DOWN));

`default_nettype wire
